// [logic/imp_parser.sv]
// Program message parser with response framing and 1 KiB byte buffers
`timescale 1ns/1ns
module imp_parser (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_end,
    output logic o_rx_ready,
    input wire logic i_dev_clear,
    input wire logic i_verbose,
    output logic o_cmd_valid,
    output imp_pkg::imp_cmd_type o_cmd,
    output logic o_arg_valid,
    output imp_pkg::imp_arg_type o_arg,
    input wire logic i_rsp_valid,
    input wire imp_pkg::imp_rsp_type i_rsp,
    output logic o_rsp_ready,
    output logic o_tx_valid,
    output logic [7:0] o_tx_byte,
    output logic o_tx_end,
    input wire logic i_tx_ready,
    output imp_pkg::imp_err_type o_err,
    output logic o_deadlock
);
    import imp_pkg::*;

    // =================================================================
    // Header lookup: direct child first, else through an optional child
    function automatic logic [3:0] node_match(input logic [MNEM_W-1:0] tok,
                                              input logic [3:0] len,
                                              input logic [2:0] p);
        logic [3:0] dir;
        logic [3:0] via;
        logic ok;
        dir = 4'h0;
        via = 4'h0;
        for (int i = 1; i < NODES; i++) begin
            ok = (len >= NODE_SHORT[i]) && (len <= NODE_FULL[i]);
            for (int k = 0; k < MNEM_CHARS; k++) begin
                if (k < int'(len) && tok[MNEM_W-1-8*k -: 8] != NODE_NAME[i][MNEM_W-1-8*k -: 8])
                    ok = 1'b0;
            end
            if (ok && NODE_PARENT[i] == p)
                dir = {1'b1, 3'(i)};
            else if (ok && NODE_OPT[NODE_PARENT[i]] && NODE_PARENT[NODE_PARENT[i]] == p)
                via = {1'b1, 3'(i)};
        end
        return dir[3] ? dir : via;
    endfunction

    // =================================================================
    // Receive buffer
    logic [8:0] rx_mem [BUF_DEPTH];
    logic [BUF_AW:0] rx_wp_r;
    logic [BUF_AW:0] rx_rp_r;
    logic rx_full;
    logic rx_empty;
    logic rx_push;
    logic rx_pop;
    logic hd_end;
    logic [7:0] hd_byte;

    // =================================================================
    // Transmit buffer and output register
    logic [7:0] tx_mem [BUF_DEPTH];
    logic [BUF_AW:0] tx_wp_r;
    logic [BUF_AW:0] tx_rp_r;
    logic tx_full;
    logic tx_empty;
    logic tx_flush;
    logic tx_pop;
    logic txw_en;
    logic [7:0] txw_byte;
    logic tx_msg_r;
    logic lf_sent_r;
    logic tx_vld_r;
    logic [7:0] tx_byte_r;
    logic tx_end_r;
    logic tx_rdy_q_r;
    imp_err_type err_r;

    // =================================================================
    // Parser state
    imp_state_type st_r;
    logic [MNEM_W-1:0] tok_r;
    logic [3:0] tok_len_r;
    logic tok_ovf_r;
    logic ustart_r;
    logic common_r;
    logic query_r;
    logic end_pend_r;
    logic in_msg_r;
    logic qmsg_r;
    logic rsp_any_r;
    logic pend_term_r;
    logic msg_done_r;
    logic semi_due_r;
    logic q_common_r;
    logic [2:0] cur_r;
    logic [2:0] level_r;
    logic [2:0] node_r;
    logic [2:0] pth_r [PATH_MAX];
    logic [1:0] pth_cnt_r;
    logic [1:0] pth_idx_r;
    logic [3:0] chr_r;
    logic cmd_vld_r;
    imp_cmd_type cmd_r;
    logic arg_vld_r;
    imp_arg_type arg_r;
    logic bad_r;

    logic [3:0] m;
    logic [2:0] fin_node;
    logic [2:0] ex_node;
    logic ex_bad;
    logic q_now;
    logic uev;
    logic tev;
    logic hd_char;
    logic [2:0] pn;
    logic [3:0] pn_len;
    logic pn_skip;
    logic [2:0] lvl_nxt;

    // =================================================================
    // Receive buffer; a 1024 byte program message fits whole
    assign rx_full = (rx_wp_r[BUF_AW] != rx_rp_r[BUF_AW]) &&
                     (rx_wp_r[BUF_AW-1:0] == rx_rp_r[BUF_AW-1:0]);
    assign rx_empty = rx_wp_r == rx_rp_r;
    assign o_rx_ready = !rx_full;
    assign rx_push = i_rx_valid && !rx_full;
    assign {hd_end, hd_byte} = rx_mem[rx_rp_r[BUF_AW-1:0]];
    assign rx_pop = !rx_empty && !end_pend_r && (st_r inside {S_HDR, S_ARG, S_SKIP});

    always_ff @(posedge i_ref_clk) begin
        if (rx_push)
            rx_mem[rx_wp_r[BUF_AW-1:0]] <= {i_rx_end, i_rx_byte};
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || i_dev_clear) begin
            rx_wp_r <= '0;
            rx_rp_r <= '0;
        end else begin
            if (rx_push)
                rx_wp_r <= rx_wp_r + 1'b1;
            if (rx_pop)
                rx_rp_r <= rx_rp_r + 1'b1;
        end
    end

    // Both buffers full means nothing drains until responses are dropped
    assign o_deadlock = rx_full && tx_full;

    // =================================================================
    // Decode of the head byte
    // LF is a terminator, never data; END on another byte ends after it
    assign hd_char = rx_pop && hd_byte != CH_LF && hd_byte != CH_SEMI;
    assign uev = (rx_pop && (hd_byte == CH_LF || hd_byte == CH_SEMI)) || end_pend_r;
    assign tev = (rx_pop && hd_byte == CH_LF) || end_pend_r;
    assign m = node_match(tok_r, tok_len_r, cur_r);
    // A non-query stopping on a node with a default child takes that child
    assign fin_node = (!q_now && NODE_DFLT[m[2:0]] != ROOT) ? NODE_DFLT[m[2:0]] : m[2:0];
    assign ex_node = (st_r == S_ARG) ? node_r : fin_node;
    assign ex_bad = !common_r && (st_r == S_ARG ? 1'b0 : (tok_ovf_r || !m[3]));
    assign q_now = query_r || (hd_char && hd_byte == CH_QUERY);
    assign lvl_nxt = tev ? ROOT : (common_r ? level_r : NODE_PARENT[ex_node]);

    // =================================================================
    // Response header emission and transmit writes
    assign pn = pth_r[pth_idx_r];
    assign pn_len = i_verbose ? NODE_FULL[pn] : NODE_SHORT[pn];
    assign pn_skip = NODE_OPT[pn] && !i_verbose;
    assign o_rsp_ready = (st_r == S_WAIT) && !tx_full && !semi_due_r;

    always_comb begin
        txw_en = 1'b0;
        txw_byte = CH_SP;
        if (st_r == S_RHDR && !tx_full) begin
            if (semi_due_r) begin
                txw_en = 1'b1;
                txw_byte = CH_SEMI;
            end else if (pth_idx_r < pth_cnt_r) begin
                txw_en = !pn_skip;
                txw_byte = (chr_r == LEN_ZERO) ? CH_COLON
                         : NODE_NAME[pn][MNEM_W-1-8*(int'(chr_r)-1) -: 8];
            end else begin
                txw_en = !q_common_r;
                txw_byte = CH_SP;
            end
        end else if (st_r == S_WAIT && !tx_full) begin
            txw_en = semi_due_r || i_rsp_valid;
            txw_byte = semi_due_r ? CH_SEMI : i_rsp.data;
        end
    end

    // =================================================================
    // Parser
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || i_dev_clear) begin
            st_r <= S_HDR;
            tok_r <= '0;
            tok_len_r <= LEN_ZERO;
            tok_ovf_r <= 1'b0;
            ustart_r <= 1'b1;
            common_r <= 1'b0;
            query_r <= 1'b0;
            end_pend_r <= 1'b0;
            in_msg_r <= 1'b0;
            qmsg_r <= 1'b0;
            rsp_any_r <= 1'b0;
            pend_term_r <= 1'b0;
            msg_done_r <= 1'b0;
            semi_due_r <= 1'b0;
            q_common_r <= 1'b0;
            cur_r <= ROOT;
            level_r <= ROOT;
            node_r <= ROOT;
            pth_r <= '{default: ROOT};
            pth_cnt_r <= '0;
            pth_idx_r <= '0;
            chr_r <= LEN_ZERO;
            cmd_vld_r <= 1'b0;
            cmd_r <= '0;
            arg_vld_r <= 1'b0;
            arg_r <= '0;
            bad_r <= 1'b0;
        end else begin
            cmd_vld_r <= 1'b0;
            arg_vld_r <= 1'b0;
            bad_r <= 1'b0;
            msg_done_r <= 1'b0;
            end_pend_r <= rx_pop && hd_end && hd_byte != CH_LF;
            if (rx_pop)
                in_msg_r <= 1'b1;
            unique case (st_r)
                S_HDR: begin
                    if (hd_char) begin
                        if (hd_byte == CH_COLON && ustart_r) begin
                            cur_r <= ROOT;
                            ustart_r <= 1'b0;
                        end else if (hd_byte == CH_COLON) begin
                            if (tok_ovf_r || !m[3]) begin
                                bad_r <= 1'b1;
                                st_r <= S_SKIP;
                            end else begin
                                cur_r <= m[2:0];
                                tok_len_r <= LEN_ZERO;
                            end
                        end else if (hd_byte == CH_SP) begin
                            if (!ustart_r && ex_bad) begin
                                bad_r <= 1'b1;
                                st_r <= S_SKIP;
                            end else if (!ustart_r) begin
                                node_r <= fin_node;
                                st_r <= S_ARG;
                            end
                        end else if (hd_byte == CH_QUERY) begin
                            query_r <= 1'b1;
                        end else begin
                            ustart_r <= 1'b0;
                            if (hd_byte == CH_STAR && ustart_r)
                                common_r <= 1'b1;
                            if (tok_len_r == 4'(MNEM_CHARS))
                                tok_ovf_r <= 1'b1;
                            else begin
                                tok_r[MNEM_W-1-8*int'(tok_len_r) -: 8] <=
                                    (hd_byte >= CH_LOW_A && hd_byte <= CH_LOW_Z) ?
                                    (hd_byte & ~CASE_BIT) : hd_byte;
                                tok_len_r <= tok_len_r + 1'b1;
                            end
                        end
                    end
                end
                S_ARG: begin
                    if (hd_char) begin
                        arg_vld_r <= 1'b1;
                        arg_r <= '{sep: hd_byte == CH_COMMA, data: hd_byte};
                    end
                end
                S_SKIP: begin
                end
                S_RHDR: begin
                    if (semi_due_r) begin
                        if (txw_en)
                            semi_due_r <= 1'b0;
                    end else if (pth_idx_r < pth_cnt_r) begin
                        if (pn_skip || (txw_en && chr_r == pn_len)) begin
                            chr_r <= LEN_ZERO;
                            pth_idx_r <= pth_idx_r + 1'b1;
                        end else if (txw_en) begin
                            chr_r <= chr_r + 1'b1;
                        end
                    end else if (!tx_full) begin
                        st_r <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    // Units of a multi-unit answer get separators here
                    if (semi_due_r && txw_en) begin
                        semi_due_r <= 1'b0;
                    end else if (o_rsp_ready && i_rsp_valid) begin
                        if (i_rsp.done) begin
                            rsp_any_r <= 1'b1;
                            st_r <= S_HDR;
                            if (pend_term_r) begin
                                pend_term_r <= 1'b0;
                                msg_done_r <= 1'b1;
                                qmsg_r <= 1'b0;
                                rsp_any_r <= 1'b0;
                                in_msg_r <= 1'b0;
                            end
                        end else if (i_rsp.eou) begin
                            semi_due_r <= 1'b1;
                        end
                    end
                end
                default: begin
                    st_r <= S_HDR;
                end
            endcase
            // Unit end: only a unit closed by ';' or a terminator runs
            if (uev && (st_r inside {S_HDR, S_ARG, S_SKIP})) begin
                ustart_r <= 1'b1;
                tok_len_r <= LEN_ZERO;
                tok_ovf_r <= 1'b0;
                common_r <= 1'b0;
                query_r <= 1'b0;
                st_r <= S_HDR;
                cur_r <= level_r;
                if (st_r == S_SKIP || (st_r == S_HDR && ustart_r)) begin
                    cur_r <= tev ? ROOT : level_r;
                end else if (ex_bad) begin
                    bad_r <= 1'b1;
                    cur_r <= tev ? ROOT : level_r;
                end else begin
                    cmd_vld_r <= 1'b1;
                    cmd_r <= '{common: common_r, query: q_now, node: ex_node,
                               len: tok_len_r, token: tok_r};
                    level_r <= lvl_nxt;
                    cur_r <= lvl_nxt;
                    if (q_now) begin
                        qmsg_r <= 1'b1;
                        st_r <= S_RHDR;
                        semi_due_r <= rsp_any_r;
                        q_common_r <= common_r;
                        chr_r <= LEN_ZERO;
                        pth_idx_r <= '0;
                        // Upper-level answers come back with full paths
                        if (common_r) begin
                            pth_cnt_r <= 2'd0;
                        end else if (NODE_PARENT[NODE_PARENT[ex_node]] != ROOT) begin
                            pth_r <= '{NODE_PARENT[NODE_PARENT[ex_node]],
                                       NODE_PARENT[ex_node], ex_node};
                            pth_cnt_r <= 2'd3;
                        end else if (NODE_PARENT[ex_node] != ROOT) begin
                            pth_r <= '{NODE_PARENT[ex_node], ex_node, ROOT};
                            pth_cnt_r <= 2'd2;
                        end else begin
                            pth_r <= '{ex_node, ROOT, ROOT};
                            pth_cnt_r <= 2'd1;
                        end
                    end
                end
                if (tev) begin
                    level_r <= ROOT;
                    if (!ex_bad && q_now && st_r != S_SKIP && !(st_r == S_HDR && ustart_r)) begin
                        pend_term_r <= 1'b1;
                    end else begin
                        msg_done_r <= qmsg_r;
                        qmsg_r <= 1'b0;
                        rsp_any_r <= 1'b0;
                        in_msg_r <= 1'b0;
                    end
                end
            end
        end
    end

    assign o_cmd_valid = cmd_vld_r;
    assign o_cmd = cmd_r;
    assign o_arg_valid = arg_vld_r;
    assign o_arg = arg_r;

    // =================================================================
    // Transmit buffer
    assign tx_full = (tx_wp_r[BUF_AW] != tx_rp_r[BUF_AW]) &&
                     (tx_wp_r[BUF_AW-1:0] == tx_rp_r[BUF_AW-1:0]);
    assign tx_empty = tx_wp_r == tx_rp_r;
    // New bytes while an answer waits unread throw that answer away
    assign tx_flush = i_dev_clear || (rx_push && tx_msg_r);
    assign tx_pop = (!tx_vld_r || i_tx_ready) && tx_msg_r && !tx_empty;

    always_ff @(posedge i_ref_clk) begin
        if (txw_en)
            tx_mem[tx_wp_r[BUF_AW-1:0]] <= txw_byte;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || tx_flush) begin
            tx_wp_r <= '0;
            tx_rp_r <= '0;
        end else begin
            if (txw_en)
                tx_wp_r <= tx_wp_r + 1'b1;
            if (tx_pop)
                tx_rp_r <= tx_rp_r + 1'b1;
        end
    end

    // =================================================================
    // Talker side; output starts only once the whole message is parsed
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || tx_flush) begin
            tx_msg_r <= 1'b0;
            lf_sent_r <= 1'b0;
            tx_vld_r <= 1'b0;
            tx_byte_r <= CH_LF;
            tx_end_r <= 1'b0;
        end else begin
            if (tx_pop) begin
                tx_vld_r <= 1'b1;
                tx_byte_r <= tx_mem[tx_rp_r[BUF_AW-1:0]];
                tx_end_r <= 1'b0;
            end else if ((!tx_vld_r || i_tx_ready) && tx_msg_r && !lf_sent_r) begin
                tx_vld_r <= 1'b1;
                tx_byte_r <= CH_LF;
                tx_end_r <= 1'b1;
                lf_sent_r <= 1'b1;
            end else if (i_tx_ready) begin
                // End flag must not outlive the terminator it marks
                tx_vld_r <= 1'b0;
                tx_end_r <= 1'b0;
            end
            if (tx_vld_r && i_tx_ready && tx_end_r) begin
                tx_msg_r <= 1'b0;
                lf_sent_r <= 1'b0;
            end
            if (msg_done_r)
                tx_msg_r <= 1'b1;
        end
    end

    assign o_tx_valid = tx_vld_r;
    assign o_tx_byte = tx_byte_r;
    assign o_tx_end = tx_end_r;

    // =================================================================
    // Protocol errors, one-cycle pulses
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            tx_rdy_q_r <= 1'b0;
            err_r <= '0;
        end else begin
            tx_rdy_q_r <= i_tx_ready;
            err_r.bad_header <= bad_r;
            err_r.interrupted <= rx_push && tx_msg_r;
            err_r.early_read <= i_tx_ready && !tx_rdy_q_r && !tx_msg_r &&
                                (in_msg_r || !rx_empty);
            err_r.no_response <= i_tx_ready && !tx_rdy_q_r && !tx_msg_r &&
                                 !in_msg_r && rx_empty;
        end
    end

    assign o_err = err_r;

endmodule

// [logic/imp_pkg.sv]
// Constants, carrier types and command tree of the program message parser
// =====================================================================
// What this block does
// - Execute message units strictly in arrival order
// - Semicolon delimits units, one command each
// - Terminator: LF, END on byte, LF with END
// - Space after header, commas between data items
// - Response ends with LF sent with END
// - Response units by semicolons, items by commas
// - Query responses returned in reception order
// - Unread response then new message: error, discard
// - Read with nothing pending or early: error
// - Only complete units of a message execute
// - Buffers hold 1024 bytes; both full stalls
// - Asterisk header is common, hierarchy independent
// - Colon marks descent to lower level
// - Remember level; resolve next unit from it
// - Leading colon resolves from the root
// - Terminator ends message, level back to root
// - Upper node query returns resendable lower settings
// - Case ignored; any prefix from upper-case truncation up to full name
// - Trailing question mark marks query, never dropped
// - Optional segments inferred, except upper query end
// - Query response is header then data; common queries return data only
// - One response message per message with queries
// - Abbreviated response headers unless full selected
package imp_pkg;

    // =================================================================
    // Characters
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_SEMI = 8'h3B;
    localparam logic [7:0] CH_QUERY = 8'h3F;
    localparam logic [7:0] CH_LOW_A = 8'h61;
    localparam logic [7:0] CH_LOW_Z = 8'h7A;
    localparam logic [7:0] CASE_BIT = 8'h20;

    // =================================================================
    // Buffers
    localparam int BUF_DEPTH = 1024;
    localparam int BUF_AW = 10;
    localparam int MNEM_CHARS = 12;
    localparam int MNEM_W = MNEM_CHARS * 8;
    localparam logic [3:0] LEN_ZERO = 4'h0;

    // =================================================================
    // Command tree; node 0 is the root, so 0 also means no default child
    localparam int NODES = 8;
    localparam int PATH_MAX = 3;
    localparam logic [2:0] ROOT = 3'h0;
    localparam logic [MNEM_W-1:0] NODE_NAME [NODES] = '{
        "            ", "SOURCE      ", "FUNCTION    ", "LEVEL       ",
        "OUTPUT      ", "STATE       ", "SYSTEM      ", "COMMUNICATE "};
    localparam logic [3:0] NODE_SHORT [NODES] = '{
        4'h0, 4'h4, 4'h4, 4'h3, 4'h4, 4'h4, 4'h4, 4'h4};
    localparam logic [3:0] NODE_FULL [NODES] = '{
        4'h0, 4'h6, 4'h8, 4'h5, 4'h6, 4'h5, 4'h6, 4'hB};
    localparam logic [2:0] NODE_PARENT [NODES] = '{
        3'h0, 3'h0, 3'h1, 3'h1, 3'h0, 3'h4, 3'h0, 3'h6};
    localparam logic [2:0] NODE_DFLT [NODES] = '{
        3'h0, 3'h0, 3'h0, 3'h0, 3'h5, 3'h0, 3'h0, 3'h0};
    localparam logic NODE_OPT [NODES] = '{
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

    // =================================================================
    // Carriers
    typedef struct packed {
        logic common;
        logic query;
        logic [2:0] node;
        logic [3:0] len;
        logic [MNEM_W-1:0] token;
    } imp_cmd_type;

    typedef struct packed {
        logic sep;
        logic [7:0] data;
    } imp_arg_type;

    typedef struct packed {
        logic done;
        logic eou;
        logic [7:0] data;
    } imp_rsp_type;

    typedef struct packed {
        logic bad_header;
        logic interrupted;
        logic early_read;
        logic no_response;
    } imp_err_type;

    typedef enum logic [4:0] {
        S_HDR = 5'b0_0001,
        S_ARG = 5'b0_0010,
        S_SKIP = 5'b0_0100,
        S_RHDR = 5'b0_1000,
        S_WAIT = 5'b1_0000
    } imp_state_type;

endpackage

// [tb/imp_ctrl_model.sv]
// Remote controller model that reads response messages
`timescale 1ns/1ns
module imp_ctrl_model (
    input wire logic i_clk,
    input wire logic i_tx_valid,
    input wire logic i_slow,
    input wire logic i_probe,
    output logic o_ready
);
    logic ph = 1'b0;
    initial o_ready = 1'b0;
    // Reads only what is offered; a probe is the one stray read
    always @(negedge i_clk) begin
        ph <= ~ph;
        o_ready <= i_probe | (i_tx_valid & (~i_slow | ph));
    end
endmodule

// [tb/imp_parser_sva.sv]
// Port assertions for the program message parser
`timescale 1ns/1ns
module imp_parser_sva (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_dev_clear,
    input wire logic o_rx_ready,
    input wire logic o_cmd_valid,
    input wire logic o_arg_valid,
    input wire logic i_rsp_valid,
    input wire imp_pkg::imp_rsp_type i_rsp,
    input wire logic o_rsp_ready,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_byte,
    input wire logic o_tx_end,
    input wire logic i_tx_ready,
    input wire imp_pkg::imp_err_type o_err,
    input wire logic o_deadlock
);
    import imp_pkg::*;
    // =========================================
    // Checks
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    tx_end_lf_a: assert property (o_tx_end |-> o_tx_valid && o_tx_byte == CH_LF)
        else $error("end flag without line feed");
    tx_hold_a: assert property (o_tx_valid && !i_tx_ready && !i_dev_clear |=>
        o_tx_valid && $stable(o_tx_byte)) else $error("unread byte changed");
    tx_once_a: assert property (o_tx_end && i_tx_ready |=> !o_tx_valid)
        else $error("output went on after terminator");
    dead_stall_a: assert property (o_deadlock |-> !o_rx_ready)
        else $error("deadlock with receive ready");
    read_err_a: assert property ($rose(i_tx_ready) && !o_tx_valid |=>
        o_err.no_response || o_err.early_read) else $error("empty read not flagged");
    arg_cmd_a: assert property (o_arg_valid |-> !o_cmd_valid)
        else $error("data byte with command");
    eou_gap_a: assert property (i_rsp_valid && o_rsp_ready && i_rsp.eou && !i_rsp.done
        |=> !o_rsp_ready) else $error("no room for unit separator");
    reset_idle_a: assert property ($fell(i_sys_rst) |-> !o_tx_valid && o_tx_byte == CH_LF
        && o_err == 4'h0) else $error("bad state after reset");
endmodule
bind imp_parser imp_parser_sva u_sva (.*);

// [tb/imp_parser_tb.sv]
// Self-checking bench for the program message parser
`timescale 1ns/1ns
module imp_parser_tb;
    import imp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rv = 1'b0, slow = 1'b0, probe = 1'b0, rsv = 1'b0;
    logic re = 1'b0, dc = 1'b0, vb = 1'b0;
    logic [7:0] rb = 8'h00;
    logic rr, cv, av, rsr, tv, te, dl, trdy;
    logic [7:0] tb_b;
    imp_cmd_type cmd;
    imp_arg_type arg;
    imp_rsp_type rsp = '0;
    imp_err_type err;
    logic [9:0] exp_q[$];
    int fails = 0, samples_checked = 0, seed = 36907;
    initial forever #5 clk = ~clk;
    imp_parser DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_rx_valid(rv), .i_rx_byte(rb),
        .i_rx_end(re), .o_rx_ready(rr), .i_dev_clear(dc), .i_verbose(vb),
        .o_cmd_valid(cv), .o_cmd(cmd), .o_arg_valid(av), .o_arg(arg), .i_rsp_valid(rsv),
        .i_rsp(rsp), .o_rsp_ready(rsr), .o_tx_valid(tv), .o_tx_byte(tb_b), .o_tx_end(te),
        .i_tx_ready(trdy), .o_err(err), .o_deadlock(dl));
    imp_ctrl_model host (.i_clk(clk), .i_tx_valid(tv), .i_slow(slow), .i_probe(probe),
        .o_ready(trdy));
    task automatic tally_and_finish(input int t);
        fails += t;
        $display("Checked %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [9:0] v);
        logic [9:0] e;
        e = exp_q.size() ? exp_q.pop_front() : 10'h3ff;
        samples_checked++;
        if (e !== v) begin
            fails++;
            $display("Error out note exp %h seen %h", e, v);
        end
    endtask
    function automatic void note(input string s, input logic [1:0] k);
        foreach (s[i]) exp_q.push_back({k[1], k[0] | (s[i] == ","), s[i]});
    endfunction
    // Holds the offer until ready is seen, bounded
    task automatic hs(input bit k);
        int w;
        w = 0;
        while ((k ? rsr : rr) !== 1'b1) begin
            @(negedge clk);
            if (++w > 99) tally_and_finish(1);
        end
        @(negedge clk);
    endtask
    task automatic send(input string s, input bit e = 1'b0);
        rv = 1'b1;
        foreach (s[k]) begin
            rb = s[k];
            re = e && k == s.len() - 1;
            hs(0);
        end
        rv = 1'b0;
        @(negedge clk);
        $display("Sent %0d bytes", s.len());
    endtask
    task automatic wait_empty;
        for (int w = 0; exp_q.size() > 0; w++) begin
            @(negedge clk);
            if (w > 999) tally_and_finish(1);
        end
    endtask
    // Instrument answers a query with two units
    initial forever begin
        @(negedge clk);
        #1;
        if (cv && cmd.query) begin
            @(negedge clk);
            rsv = 1'b1;
            rsp = {1'b0, 1'b1, 8'h31};
            hs(1);
            rsp = {1'b1, 1'b0, 8'h32};
            hs(1);
            rsv = 1'b0;
        end
    end
    always @(negedge clk) begin
        #1;
        if (cv) chk({2'b10, 3'h0, cmd.common, cmd.query, cmd.common ? 3'h0 : cmd.node});
        if (av) chk({1'b0, arg.sep, arg.data});
        if (tv && trdy) chk({1'b1, te ^ (tb_b != CH_LF), tb_b});
        if (|err) chk({6'h3f, err});
    end
    initial begin
        logic [7:0] d;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        note("5", 0);
        send("sour:lev 5");
        wait_empty;
        dc = 1'b1;
        @(negedge clk);
        dc = 1'b0;
        d = 8'h30 + 8'($random(seed) & 7);
        exp_q.push_back({2'b00, d});
        exp_q.push_back(10'h205);
        send($sformatf(":OUTP %c\n", d));
        note("2,3", 0);
        exp_q.push_back(10'h203);
        note("4", 0);
        exp_q.push_back(10'h202);
        send("sour:lev 2,3;func 4\n");
        exp_q.push_back(10'h3f8);
        exp_q.push_back(10'h210);
        send("func 1;*CLS\n");
        exp_q.push_back(10'h209);
        note(":SOUR 1;2\n", 3);
        slow <= 1'b1;
        send(":SOUR?\n");
        wait_empty;
        exp_q.push_back(10'h3f1);
        probe <= 1'b1;
        @(negedge clk);
        probe <= 1'b0;
        wait_empty;
        vb = 1'b1;
        exp_q.push_back(10'h209);
        note(":SOURCE 1;2\n", 3);
        send(":SOUR?", 1'b1);
        wait_empty;
        tally_and_finish(0);
    end
endmodule
